/* fcsl_pkg.sv */
/*
 * Package for the flash command controller: AXI4-Lite register map,
 * command codes, unlock addresses and parallel bus timing counts.
 * Assumes a 125 MHz system clock and an external asynchronous NOR flash.
 */
package fcsl_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL    = 8'h00;
    localparam logic [7:0] OFF_ADDR    = 8'h04;
    localparam logic [7:0] OFF_DATA    = 8'h08;
    localparam logic [7:0] OFF_STATUS  = 8'h0C;
    localparam logic [7:0] OFF_RDATA   = 8'h10;
    // Control fields
    localparam int CTRL_OP_LSB  = 0;
    localparam int CTRL_OP_W    = 4;
    localparam int CTRL_BYTE    = 4;
    localparam int CTRL_START   = 8;
    // Status fields
    localparam int ST_BUSY      = 0;
    localparam int ST_DONE      = 1;
    localparam int ST_FAIL      = 2;
    localparam int ST_BYPASS    = 3;
    localparam int ST_SUSP      = 4;
    // Operations
    localparam logic [3:0] OP_RESET     = 4'h0;
    localparam logic [3:0] OP_READ      = 4'h1;
    localparam logic [3:0] OP_IDREAD    = 4'h2;
    localparam logic [3:0] OP_PROGRAM   = 4'h3;
    localparam logic [3:0] OP_BYP_ENTER = 4'h4;
    localparam logic [3:0] OP_BYP_PROG  = 4'h5;
    localparam logic [3:0] OP_BYP_EXIT  = 4'h6;
    localparam logic [3:0] OP_CHIP_ERS  = 4'h7;
    localparam logic [3:0] OP_SECT_ERS  = 4'h8;
    localparam logic [3:0] OP_SECT_ADD  = 4'h9;
    localparam logic [3:0] OP_SUSPEND   = 4'hA;
    localparam logic [3:0] OP_RESUME    = 4'hB;
    // Command codes
    localparam logic [7:0] CMD_RESET   = 8'hF0;
    localparam logic [7:0] CMD_UNLK1   = 8'hAA;
    localparam logic [7:0] CMD_UNLK2   = 8'h55;
    localparam logic [7:0] CMD_ID      = 8'h90;
    localparam logic [7:0] CMD_PROG    = 8'hA0;
    localparam logic [7:0] CMD_BYPASS  = 8'h20;
    localparam logic [7:0] CMD_BYPX2   = 8'h00;
    localparam logic [7:0] CMD_ERSU    = 8'h80;
    localparam logic [7:0] CMD_CHIP    = 8'h10;
    localparam logic [7:0] CMD_SECT    = 8'h30;
    localparam logic [7:0] CMD_SUSP    = 8'hB0;
    localparam logic [7:0] CMD_RESUME  = 8'h30;
    // Unlock addresses, word and byte mode
    localparam logic [18:0] ADR_W_555 = 19'h0_0555;
    localparam logic [18:0] ADR_W_2AA = 19'h0_02AA;
    localparam logic [18:0] ADR_B_AAA = 19'h0_0AAA;
    localparam logic [18:0] ADR_B_555 = 19'h0_0555;
    localparam int FL_ADDR_W = 19;
    // Bus timing
    localparam int CLK_MHZ       = 125;
    localparam int T_PULSE_NS    = 48;
    localparam int T_SETUP_NS    = 16;
    localparam int PULSE_CYC     = (T_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int SETUP_CYC     = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
    localparam int T_POLL_US     = 2000000;
    localparam int POLL_LIMIT    = T_POLL_US * CLK_MHZ / 64;
endpackage

/* fcsl_host.sv */
/*
 * Host controller for an asynchronous boot-sector NOR flash. Software issues
 * operations over AXI4-Lite; the controller plays the unlock and command
 * write cycles on the flash pins and polls completion on the polling bit.
 * Assumes the flash data bus is shared: dq_out/dq_oe drive, dq_in samples.
 */
// How it works
// - Writing F0 anywhere returns flash to array reading, also after id mode
// - All sequence cycles are writes, id sequence ends with one read
// - Bypass program is issued only after bypass entry
// - Bypass exit writes 90 then 00 and clears bypass mode
// - Erase polling reads at the given sector address
// - After the bit turns true, one more read fetches valid data
// - After timing-limit flag is seen, the polling bit is re-read once
// - Program polling reads at the programmed address
// - Chip erase polls at the software-given address
// - Extra sector erase writes only 30 at a sector address
`timescale 1ns/100ps
module fcsl_host
    import fcsl_pkg::*;
(
    input  wire logic                  clk_sys,
    input  wire logic                  sys_rst,
    input  wire logic [7:0]            s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [7:0]            s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    output logic [FL_ADDR_W-1:0]       fl_addr,
    output logic                       fl_ce_n,
    output logic                       fl_we_n,
    output logic                       fl_oe_n,
    output logic                       fl_reset_n,
    output logic [15:0]                dq_out,
    output logic                       dq_oe,
    input  wire logic [15:0]           dq_in
);
    import fcsl_pkg::*;

    typedef enum logic [3:0] {
        FS_IDLE, FS_SETUP, FS_PULSE, FS_HOLD, FS_NEXT, FS_RSETUP, FS_RPULSE, FS_RDONE
    } fcsl_state_e;

    // Command step table entry: address, data, is last
    function automatic logic [27:0] step_of(input logic [3:0] op, input logic [2:0] i,
                                            input logic bm);
        logic [18:0] a1;
        logic [18:0] a2;
        a1 = bm ? ADR_B_AAA : ADR_W_555;
        a2 = bm ? ADR_B_555 : ADR_W_2AA;
        step_of = {1'b1, 19'h0_0000, CMD_RESET};
        if (i == 3'd0 && op != OP_RESET && op != OP_BYP_PROG && op != OP_BYP_EXIT
            && op != OP_SUSPEND && op != OP_RESUME && op != OP_SECT_ADD) begin
            step_of = {1'b0, a1, CMD_UNLK1};
        end else if (i == 3'd1 && op != OP_RESET && op != OP_BYP_PROG
                     && op != OP_BYP_EXIT) begin
            step_of = {1'b0, a2, CMD_UNLK2};
        end else begin
            unique case (op)
                OP_IDREAD:    step_of = {1'b1, a1, CMD_ID};
                OP_PROGRAM:   step_of = (i == 3'd2) ? {1'b0, a1, CMD_PROG}
                                                    : {1'b1, 19'h0_0000, 8'h00};
                OP_BYP_ENTER: step_of = {1'b1, a1, CMD_BYPASS};
                OP_BYP_PROG:  step_of = (i == 3'd0) ? {1'b0, 19'h0_0000, CMD_PROG}
                                                    : {1'b1, 19'h0_0000, 8'h00};
                OP_BYP_EXIT:  step_of = (i == 3'd0) ? {1'b0, 19'h0_0000, CMD_ID}
                                                    : {1'b1, 19'h0_0000, CMD_BYPX2};
                OP_CHIP_ERS, OP_SECT_ERS: begin
                    if (i == 3'd2) step_of = {1'b0, a1, CMD_ERSU};
                    else if (i == 3'd3) step_of = {1'b0, a1, CMD_UNLK1};
                    else if (i == 3'd4) step_of = {1'b0, a2, CMD_UNLK2};
                    else if (op == OP_CHIP_ERS) step_of = {1'b1, a1, CMD_CHIP};
                    else step_of = {1'b1, 19'h0_0000, CMD_SECT};
                end
                OP_SECT_ADD:  step_of = {1'b1, 19'h0_0000, CMD_SECT};
                OP_SUSPEND:   step_of = {1'b1, 19'h0_0000, CMD_SUSP};
                OP_RESUME:    step_of = {1'b1, 19'h0_0000, CMD_RESUME};
                default:      step_of = {1'b1, 19'h0_0000, CMD_RESET};
            endcase
        end
    endfunction

    // Step that carries the software address (program or sector address)
    function automatic logic uses_addr(input logic [3:0] op, input logic last);
        uses_addr = last && (op == OP_PROGRAM || op == OP_BYP_PROG
                             || op == OP_SECT_ERS || op == OP_SECT_ADD);
    endfunction

    fcsl_state_e      st_reg, st_next;
    logic [3:0]       op_reg, op_next;
    logic             bm_reg, bm_next;
    logic [2:0]       idx_reg, idx_next;
    logic [7:0]       cnt_reg, cnt_next;
    logic [31:0]      poll_reg, poll_next;
    logic             polling_reg, polling_next;
    logic             limit_seen_reg, limit_seen_next;
    logic             final_rd_reg, final_rd_next;
    logic [18:0]      adr_sw_reg, adr_sw_next;
    logic [15:0]      dat_sw_reg, dat_sw_next;
    logic [15:0]      rdata_reg, rdata_next;
    logic             busy_reg, busy_next, done_reg, done_next, fail_reg, fail_next;
    logic             byp_reg, byp_next, susp_reg, susp_next, sect_reg, sect_next;
    logic [18:0]      fa_reg, fa_next;
    logic             ce_reg, ce_next, we_reg, we_next, oe_reg, oe_next;
    logic [15:0]      dqo_reg, dqo_next;
    logic             dqe_reg, dqe_next;
    logic [15:0]      s1_reg, s2_reg, s3_reg, dqs_reg, dqs_next;
    logic             awr_reg, awr_next, wr_reg, wr_next, bv_reg, bv_next;
    logic             arr_reg, arr_next, rv_reg, rv_next;
    logic [31:0]      rd_reg, rd_next;
    logic [1:0]       br_reg, br_next, rr_reg, rr_next;
    logic             aw_got_reg, aw_got_next, w_got_reg, w_got_next;
    logic [7:0]       awa_reg, awa_next;
    logic [31:0]      wd_reg, wd_next;
    logic [27:0]      stp;
    logic             start;

    assign stp = step_of(op_reg, idx_reg, bm_reg);

    always_comb begin
        awr_next = awr_reg; wr_next = wr_reg; bv_next = bv_reg; br_next = br_reg;
        arr_next = arr_reg; rv_next = rv_reg; rd_next = rd_reg; rr_next = rr_reg;
        aw_got_next = aw_got_reg; w_got_next = w_got_reg;
        awa_next = awa_reg; wd_next = wd_reg; start = 1'b0;
        if (s_axi_awvalid && awr_reg) begin
            awa_next = s_axi_awaddr; aw_got_next = 1'b1; awr_next = 1'b0;
        end
        if (s_axi_wvalid && wr_reg) begin
            wd_next = s_axi_wdata; w_got_next = 1'b1; wr_next = 1'b0;
        end
        if (aw_got_reg && w_got_reg && !bv_reg) begin
            bv_next = 1'b1; aw_got_next = 1'b0; w_got_next = 1'b0;
            br_next = (awa_reg == OFF_CTRL || awa_reg == OFF_ADDR || awa_reg == OFF_DATA)
                      ? 2'b00 : 2'b10;
            start = (awa_reg == OFF_CTRL) && wd_reg[CTRL_START] && !busy_reg;
        end
        if (bv_reg && s_axi_bready) begin
            bv_next = 1'b0; awr_next = 1'b1; wr_next = 1'b1;
        end
        if (s_axi_arvalid && arr_reg) begin
            arr_next = 1'b0; rv_next = 1'b1; rr_next = 2'b00;
            unique case (s_axi_araddr)
                OFF_CTRL:   rd_next = {27'h000_0000, bm_reg, op_reg};
                OFF_ADDR:   rd_next = {13'h0000, adr_sw_reg};
                OFF_DATA:   rd_next = {16'h0000, dat_sw_reg};
                OFF_STATUS: rd_next = {27'h000_0000, susp_reg, byp_reg, fail_reg,
                                       done_reg, busy_reg};
                OFF_RDATA:  rd_next = {16'h0000, rdata_reg};
                default: begin
                    rd_next = 32'h0000_0000; rr_next = 2'b10;
                end
            endcase
        end
        if (rv_reg && s_axi_rready) begin
            rv_next = 1'b0; arr_next = 1'b1;
        end
    end

    always_comb begin
        st_next = st_reg; op_next = op_reg; bm_next = bm_reg; idx_next = idx_reg;
        cnt_next = cnt_reg; poll_next = poll_reg; polling_next = polling_reg;
        limit_seen_next = limit_seen_reg; final_rd_next = final_rd_reg;
        adr_sw_next = adr_sw_reg; dat_sw_next = dat_sw_reg; rdata_next = rdata_reg;
        busy_next = busy_reg; done_next = done_reg; fail_next = fail_reg;
        byp_next = byp_reg; susp_next = susp_reg; sect_next = sect_reg;
        fa_next = fa_reg; ce_next = ce_reg; we_next = we_reg; oe_next = oe_reg;
        dqo_next = dqo_reg; dqe_next = dqe_reg; dqs_next = dqs_reg;
        if (s2_reg == s3_reg) dqs_next = s3_reg;
        if (aw_got_reg && w_got_reg && !bv_reg && !busy_reg) begin
            if (awa_reg == OFF_ADDR) adr_sw_next = wd_reg[18:0];
            if (awa_reg == OFF_DATA) dat_sw_next = wd_reg[15:0];
            if (awa_reg == OFF_CTRL) begin
                op_next = wd_reg[CTRL_OP_LSB +: CTRL_OP_W];
                bm_next = wd_reg[CTRL_BYTE];
            end
        end
        unique case (st_reg)
            FS_IDLE: if (start) begin
                op_next = wd_reg[CTRL_OP_LSB +: CTRL_OP_W];
                bm_next = wd_reg[CTRL_BYTE];
                busy_next = 1'b1; done_next = 1'b0; fail_next = 1'b0;
                idx_next = 3'd0; polling_next = 1'b0; limit_seen_next = 1'b0;
                final_rd_next = 1'b0; poll_next = 32'h0000_0000;
                if ((wd_reg[CTRL_OP_LSB +: CTRL_OP_W] == OP_BYP_PROG && !byp_reg)
                    || (wd_reg[CTRL_OP_LSB +: CTRL_OP_W] == OP_SUSPEND && !sect_reg)
                    || (wd_reg[CTRL_OP_LSB +: CTRL_OP_W] == OP_RESUME && !susp_reg)) begin
                    busy_next = 1'b0; done_next = 1'b1; fail_next = 1'b1;
                end else if (wd_reg[CTRL_OP_LSB +: CTRL_OP_W] == OP_READ) begin
                    fa_next = adr_sw_reg; cnt_next = 8'd0; st_next = FS_RSETUP;
                end else begin
                    st_next = FS_NEXT;
                end
            end
            FS_NEXT: begin
                // Sector or program address only where required; else zero upper bits
                fa_next = uses_addr(op_reg, stp[27]) ? adr_sw_reg : stp[26:8];
                dqo_next = uses_addr(op_reg, stp[27]) && op_reg != OP_SECT_ERS
                           && op_reg != OP_SECT_ADD ? dat_sw_reg
                           : {8'h00, stp[7:0]};
                dqe_next = 1'b1; oe_next = 1'b1; cnt_next = 8'd0;
                st_next = FS_SETUP;
            end
            FS_SETUP: begin
                cnt_next = cnt_reg + 8'd1;
                if (cnt_reg == 8'(SETUP_CYC)) begin
                    ce_next = 1'b0; we_next = 1'b0; cnt_next = 8'd0;
                    st_next = FS_PULSE;
                end
            end
            FS_PULSE: begin
                cnt_next = cnt_reg + 8'd1;
                if (cnt_reg == 8'(PULSE_CYC)) begin
                    we_next = 1'b1; ce_next = 1'b1; cnt_next = 8'd0;
                    st_next = FS_HOLD;
                end
            end
            FS_HOLD: begin
                cnt_next = cnt_reg + 8'd1;
                if (cnt_reg == 8'(SETUP_CYC)) begin
                    dqe_next = 1'b0; cnt_next = 8'd0;
                    if (!stp[27]) begin
                        idx_next = idx_reg + 3'd1; st_next = FS_NEXT;
                    end else begin
                        unique case (op_reg)
                            OP_BYP_ENTER: byp_next = 1'b1;
                            OP_BYP_EXIT, OP_RESET: byp_next = 1'b0;
                            OP_SUSPEND: susp_next = 1'b1;
                            OP_RESUME: susp_next = 1'b0;
                            default: ;
                        endcase
                        if (op_reg == OP_RESET) begin
                            susp_next = 1'b0; sect_next = 1'b0;
                        end
                        if (op_reg == OP_SECT_ERS || op_reg == OP_SECT_ADD) sect_next = 1'b1;
                        if (op_reg == OP_CHIP_ERS) sect_next = 1'b0;
                        if (op_reg == OP_IDREAD) begin
                            fa_next = adr_sw_reg; st_next = FS_RSETUP;
                        end else if (op_reg == OP_PROGRAM || op_reg == OP_BYP_PROG
                                     || op_reg == OP_CHIP_ERS || op_reg == OP_SECT_ERS
                                     || op_reg == OP_SECT_ADD) begin
                            polling_next = 1'b1; fa_next = adr_sw_reg;
                            st_next = FS_RSETUP;
                        end else begin
                            busy_next = 1'b0; done_next = 1'b1; st_next = FS_IDLE;
                        end
                    end
                end
            end
            FS_RSETUP: begin
                oe_next = 1'b0; ce_next = 1'b0; cnt_next = 8'd0;
                st_next = FS_RPULSE;
            end
            FS_RPULSE: begin
                cnt_next = cnt_reg + 8'd1;
                if (cnt_reg == 8'(PULSE_CYC + 4)) begin
                    oe_next = 1'b1; ce_next = 1'b1; cnt_next = 8'd0;
                    st_next = FS_RDONE;
                end
            end
            FS_RDONE: begin
                rdata_next = dqs_reg;
                poll_next = poll_reg + 32'd1;
                st_next = FS_RSETUP;
                if (!polling_reg || final_rd_reg) begin
                    busy_next = 1'b0; done_next = 1'b1; st_next = FS_IDLE;
                    if (op_reg == OP_SECT_ERS || op_reg == OP_SECT_ADD
                        || op_reg == OP_CHIP_ERS) sect_next = 1'b0;
                end else if ((op_reg == OP_PROGRAM || op_reg == OP_BYP_PROG)
                             ? (dqs_reg[7] == dat_sw_reg[7]) : dqs_reg[7]) begin
                    final_rd_next = 1'b1;
                end else if (limit_seen_reg) begin
                    fail_next = 1'b1; busy_next = 1'b0; done_next = 1'b1;
                    st_next = FS_IDLE;
                end else if (dqs_reg[5] || poll_reg == 32'(POLL_LIMIT)) begin
                    limit_seen_next = 1'b1;
                end
            end
            default: st_next = FS_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            st_reg <= FS_IDLE; op_reg <= 4'h0; bm_reg <= 1'b0; idx_reg <= 3'd0;
            cnt_reg <= 8'd0; poll_reg <= 32'h0000_0000; polling_reg <= 1'b0;
            limit_seen_reg <= 1'b0; final_rd_reg <= 1'b0;
            adr_sw_reg <= 19'h0_0000; dat_sw_reg <= 16'h0000; rdata_reg <= 16'h0000;
            busy_reg <= 1'b0; done_reg <= 1'b0; fail_reg <= 1'b0;
            byp_reg <= 1'b0; susp_reg <= 1'b0; sect_reg <= 1'b0;
            fa_reg <= 19'h0_0000; ce_reg <= 1'b1; we_reg <= 1'b1; oe_reg <= 1'b1;
            dqo_reg <= 16'h0000; dqe_reg <= 1'b0; dqs_reg <= 16'h0000;
            s1_reg <= 16'h0000; s2_reg <= 16'h0000; s3_reg <= 16'h0000;
            awr_reg <= 1'b1; wr_reg <= 1'b1; bv_reg <= 1'b0; br_reg <= 2'b00;
            arr_reg <= 1'b1; rv_reg <= 1'b0; rd_reg <= 32'h0000_0000; rr_reg <= 2'b00;
            aw_got_reg <= 1'b0; w_got_reg <= 1'b0; awa_reg <= 8'h00;
            wd_reg <= 32'h0000_0000;
        end else begin
            st_reg <= st_next; op_reg <= op_next; bm_reg <= bm_next; idx_reg <= idx_next;
            cnt_reg <= cnt_next; poll_reg <= poll_next; polling_reg <= polling_next;
            limit_seen_reg <= limit_seen_next; final_rd_reg <= final_rd_next;
            adr_sw_reg <= adr_sw_next; dat_sw_reg <= dat_sw_next; rdata_reg <= rdata_next;
            busy_reg <= busy_next; done_reg <= done_next; fail_reg <= fail_next;
            byp_reg <= byp_next; susp_reg <= susp_next; sect_reg <= sect_next;
            fa_reg <= fa_next; ce_reg <= ce_next; we_reg <= we_next; oe_reg <= oe_next;
            dqo_reg <= dqo_next; dqe_reg <= dqe_next; dqs_reg <= dqs_next;
            s1_reg <= dq_in; s2_reg <= s1_reg; s3_reg <= s2_reg;
            awr_reg <= awr_next; wr_reg <= wr_next; bv_reg <= bv_next; br_reg <= br_next;
            arr_reg <= arr_next; rv_reg <= rv_next; rd_reg <= rd_next; rr_reg <= rr_next;
            aw_got_reg <= aw_got_next; w_got_reg <= w_got_next; awa_reg <= awa_next;
            wd_reg <= wd_next;
        end
    end

    assign s_axi_awready = awr_reg;
    assign s_axi_wready  = wr_reg;
    assign s_axi_bvalid  = bv_reg;
    assign s_axi_bresp   = br_reg;
    assign s_axi_arready = arr_reg;
    assign s_axi_rvalid  = rv_reg;
    assign s_axi_rdata   = rd_reg;
    assign s_axi_rresp   = rr_reg;
    assign fl_addr       = fa_reg;
    assign fl_ce_n       = ce_reg;
    assign fl_we_n       = we_reg;
    assign fl_oe_n       = oe_reg;
    assign fl_reset_n    = 1'b1;
    assign dq_out        = dqo_reg;
    assign dq_oe         = dqe_reg;
endmodule // fcsl_host

/* fcsl_host_asserts.sv */
/* Checker for fcsl_host: flash pin strobes and AXI answer timing.
   Assumes it is bound to every fcsl_host and sees only its ports. */
`timescale 1ns/100ps
module fcsl_host_asserts (
    input wire logic        clk_sys, sys_rst, fl_ce_n, fl_we_n, fl_oe_n, dq_oe,
    input wire logic        s_axi_bvalid, s_axi_awready, s_axi_arvalid, s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic [18:0] fl_addr,
    input wire logic [15:0] dq_out
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    a_we_in_ce: assert property (!fl_we_n |-> !fl_ce_n && fl_oe_n && dq_oe)
        else $error("write strobe outside a selected write");
    a_read_quiet: assert property (!fl_oe_n |-> !dq_oe && fl_we_n)
        else $error("bus driven during a read");
    a_pulse_len: assert property ($fell(fl_we_n) |-> !fl_we_n [*7] ##1 fl_we_n)
        else $error("write pulse length wrong");
    a_data_hold: assert property (!fl_we_n |=> dq_oe && $stable(dq_out))
        else $error("data not held past the strobe");
    a_addr_hold: assert property (!fl_ce_n |=> fl_ce_n || $stable(fl_addr))
        else $error("address moved while selected");
    a_ce_setup: assert property ($fell(fl_ce_n) |-> $stable(fl_addr))
        else $error("address changed as select fell");
    a_b_blocks_aw: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("write address ready during response");
    a_r_follows: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
endmodule // fcsl_host_asserts
bind fcsl_host fcsl_host_asserts chk_u (.clk_sys, .sys_rst, .fl_ce_n, .fl_we_n, .fl_oe_n,
    .dq_oe, .s_axi_bvalid, .s_axi_awready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .fl_addr, .dq_out);

/* fcsl_flash_model.sv */
/* Flash partner model: logs write cycles, runs program and erase for a
   fixed span and answers reads with polling status. Assumes ns time. */
`timescale 1ns/100ps
module fcsl_flash_model (
    input wire logic        fl_ce_n, fl_we_n, fl_oe_n,
    input wire logic [18:0] fl_addr,
    input wire logic [15:0] dq_out,
    output logic     [15:0] dq_in
);
    logic [31:0] log_q[$];
    logic [18:0] adr_lat;
    logic [15:0] pd = 16'h0000;
    logic        pend = 1'b0;
    logic        ers = 1'b0;
    logic        idm = 1'b0;
    realtime     bt = 0;
    wire         wr_n = fl_we_n | fl_ce_n;
    wire         rd_sel = !fl_oe_n && !fl_ce_n;
    initial dq_in = 16'h0000;
    always @(negedge wr_n) adr_lat = fl_addr;
    always @(posedge wr_n) begin
        log_q.push_back({5'h00, adr_lat, dq_out[7:0]});
        if (pend) begin
            pd = dq_out;
            ers = 1'b0;
            bt = $realtime + 2000;
        end else if (dq_out[7:0] == 8'h10 || dq_out[7:0] == 8'h30) begin
            ers = 1'b1;
            bt = $realtime + 3000;
        end
        pend = (dq_out[7:0] == 8'hA0) && !pend;
        idm = dq_out[7:0] == 8'h90 ? adr_lat != 19'h0 : idm && dq_out[7:0] != 8'hF0;
    end
    // Deselected bus shows the inverse of the last value
    always @(rd_sel) begin
        if (!rd_sel) dq_in = ~dq_in;
        else if (idm) dq_in = {15'h0000, fl_addr[12]};
        else if ($realtime < bt) dq_in = {8'h00, !ers & ~pd[7], 7'h55};
        else dq_in = ers ? 16'hFFFF : pd;
    end
endmodule // fcsl_flash_model

/* fcsl_tb.sv */
/* Self-checking bench for fcsl_host with the flash model on its pins.
   Assumes the package register map and a 125 MHz clock. */
`timescale 1ns/100ps
module testbench;
    import fcsl_pkg::*;
    logic        clk_sys = 0, sys_rst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0;
    logic        s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        fl_ce_n, fl_we_n, fl_oe_n, dq_oe;
    logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rv, sd, seed = 32'h0001_0AA5;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    logic [18:0] fl_addr;
    logic [15:0] dq_out, dq_in;
    logic [3:0]  bad[3] = '{OP_BYP_PROG, OP_SUSPEND, OP_RESUME};
    int          mismatches = 0, comparisons = 0;
    always #4 clk_sys = ~clk_sys;
    fcsl_host dut_u (.clk_sys, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .fl_addr, .fl_ce_n,
        .fl_we_n, .fl_oe_n, .fl_reset_n(), .dq_out, .dq_oe, .dq_in);
    fcsl_flash_model fm_u (.fl_ce_n, .fl_we_n, .fl_oe_n, .fl_addr, .dq_out, .dq_in);
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Expected unlock and command cycle for step j of a program
    function automatic logic [31:0] ev(input logic bm, input int j);
        if (j == 1) return {5'h00, bm ? ADR_B_555 : ADR_W_2AA, 8'h55};
        return {5'h00, bm ? ADR_B_AAA : ADR_W_555, j == 0 ? 8'hAA : 8'hA0};
    endfunction
    task automatic chk(input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        do begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 0;
        rsp = s_axi_bresp;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 0;
        rv = s_axi_rdata;
        rsp = s_axi_rresp;
    endtask
    task automatic op(input logic [3:0] o, input logic bm, input logic [2:0] exp);
        wr(OFF_CTRL, {23'h0, 1'b1, 3'h0, bm, o});
        do rd(OFF_STATUS); while (rv[ST_BUSY] !== 1'b0);
        chk(rv & 32'h7, {29'h0, exp});
        $display("op %h done", o);
    endtask
    task automatic print_verdict();
        $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Whole run needs well under 200 us
    initial begin
        #400_000;
        mismatches++;
        print_verdict();
    end
    initial begin
        repeat (5) @(posedge clk_sys);
        sys_rst <= 0;
        for (int k = 0; k < 4; k++) begin
            sd = rnd();
            fm_u.log_q.delete();
            wr(OFF_ADDR, {13'h0, sd[18:0]});
            wr(OFF_DATA, {16'h0, sd[31:16]});
            op(OP_PROGRAM, k[0], 3'b010);
            for (int j = 0; j < 3; j++) chk(fm_u.log_q[j], ev(k[0], j));
            chk(fm_u.log_q[3], {5'h0, sd[18:0], sd[23:16]});
            rd(OFF_RDATA);
            chk(rv, {16'h0, sd[31:16]});
        end
        fm_u.log_q.delete();
        op(OP_SECT_ERS, 0, 3'b010);
        chk(fm_u.log_q[2] & 32'hFF, 32'h80);
        chk(fm_u.log_q[5], {5'h0, sd[18:0], 8'h30});
        rd(OFF_RDATA);
        chk(rv, 32'h0000_FFFF);
        op(OP_CHIP_ERS, 0, 3'b010);
        chk(fm_u.log_q[$] & 32'hFF, 32'h10);
        op(OP_BYP_ENTER, 0, 3'b010);
        chk(rv[ST_BYPASS], 1);
        fm_u.log_q.delete();
        op(OP_BYP_PROG, 0, 3'b010);
        chk(fm_u.log_q[0], 32'hA0);
        rd(OFF_RDATA);
        chk(rv, {16'h0, sd[31:16]});
        op(OP_BYP_EXIT, 0, 3'b010);
        chk(rv[ST_BYPASS], 0);
        chk({fm_u.log_q[$-1][7:0], fm_u.log_q[$][7:0]}, 32'h9000);
        foreach (bad[i]) op(bad[i], 0, 3'b110);
        op(OP_IDREAD, 0, 3'b010);
        rd(OFF_RDATA);
        chk(rv, {31'h0, sd[12]});
        op(OP_RESET, 1, 3'b010);
        chk(fm_u.log_q[$] & 32'hFF, 32'hF0);
        rd(OFF_CTRL);
        chk(rv & 32'h1F, 32'h10);
        wr(8'h14, 0);
        chk({30'h0, rsp}, 32'h2);
        rd(8'h1C);
        chk({30'h0, rsp}, 32'h2);
        print_verdict();
    end
endmodule // testbench
